// ### timer_ctl_pkg.sv
// Constants, register map and types shared by the timer control block
package timer_ctl_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int MODE_W = 5;
  localparam int PRESC_W = 3;
  localparam int DIV_W = 7;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_LIMIT = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_PRESC_LSB = 4;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ERS_BIT = 1;
  localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] PERIOD_RST = 8'hFF;
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  localparam logic [PRESC_W-1:0] PRESC_RST = 3'h0;

  // ****************************************
  // Mode field: two-bit class, three-bit sub-mode
  // ****************************************
  localparam logic [1:0] CLS_ONESHOT = 2'h1;
  localparam logic [1:0] CLS_MONO = 2'h2;
  localparam logic [2:0] SUB_SOFT = 3'h0;
  localparam logic [2:0] SUB_RISE = 3'h1;
  localparam logic [2:0] SUB_FALL = 3'h2;
  localparam logic [2:0] SUB_ANY = 3'h3;
  localparam logic [2:0] SUB_RISE_RST = 3'h4;
  localparam logic [2:0] SUB_FALL_RST = 3'h5;
  localparam logic [2:0] SUB_LVL_LOW = 3'h6;
  localparam logic [2:0] SUB_LVL_HIGH = 3'h7;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {RUN_IDLE, RUN_ACTIVE} run_state_t;

endpackage : timer_ctl_pkg

// ### timer_tick_if.sv
// Carrier between the timer core and its prescaler and edge sampler
`timescale 1ns/10ps
interface timer_tick_if;
  logic [timer_ctl_pkg::PRESC_W-1:0] presc_sel;
  logic presc_clr;
  logic ext_level;
  logic tick;
  logic ers_now;
  logic ers_rise;
  logic ers_fall;

  modport gen (input presc_sel, input presc_clr, input ext_level,
               output tick, output ers_now, output ers_rise, output ers_fall);
  modport core (output presc_sel, output presc_clr, output ext_level,
                input tick, input ers_now, input ers_rise, input ers_fall);
endinterface : timer_tick_if

// ### timer_tick_gen.sv
// Prescaler for the timer clock and edge sampler for the external reset source
`timescale 1ns/10ps
module timer_tick_gen (
  input wire logic clock,
  input wire logic resetn,
  timer_tick_if.gen tk
);

  logic [timer_ctl_pkg::DIV_W-1:0] div_r;
  logic [timer_ctl_pkg::DIV_W-1:0] div_mask;
  logic ers_prev_r;

  // ****************************************
  // Prescaler: one tick every 2^presc_sel clocks
  // ****************************************
  assign div_mask = ~({timer_ctl_pkg::DIV_W{1'b1}} << tk.presc_sel);
  assign tk.tick = ((div_r & div_mask) == div_mask) && !tk.presc_clr;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      div_r <= '0;
    else if (tk.presc_clr || tk.tick)
      div_r <= '0;
    else
      div_r <= div_r + 7'h01;
  end

  // ****************************************
  // Source is sampled once per timer clock
  // ****************************************
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ers_prev_r <= 1'b0;
    else if (tk.tick)
      ers_prev_r <= tk.ext_level;
  end

  assign tk.ers_now = tk.ext_level;
  assign tk.ers_rise = tk.tick && tk.ext_level && !ers_prev_r;
  assign tk.ers_fall = tk.tick && !tk.ext_level && ers_prev_r;

endmodule : timer_tick_gen

// ### timer_oneshot_monostable_ctl.sv
// Timer start, stop and reset control for one-shot and monostable modes, AXI4-Lite registers
`timescale 1ns/10ps

module timer_oneshot_monostable_ctl (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ext_reset_source,
  input wire logic [timer_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [timer_ctl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [timer_ctl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [timer_ctl_pkg::CNT_W-1:0] count_value,
  output logic period_event,
  output logic timer_running
);

  // ****************************************
  // Declarations
  // ****************************************
  timer_tick_if tk ();

  logic [timer_ctl_pkg::ADDR_W-1:0] awaddr_r;
  logic aw_held_r;
  logic [timer_ctl_pkg::DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [timer_ctl_pkg::DATA_W-1:0] rdata_r;

  logic wr_do;
  logic wr_low;
  logic wr_ctrl;
  logic wr_limit;
  logic wr_count;
  logic wr_period;
  logic wr_mapped;
  logic rd_do;
  logic rd_mapped;
  logic [timer_ctl_pkg::DATA_W-1:0] rd_mux;

  logic on_r;
  logic [timer_ctl_pkg::PRESC_W-1:0] presc_r;
  logic [timer_ctl_pkg::MODE_W-1:0] mode_r;
  logic [timer_ctl_pkg::CNT_W-1:0] count_r;
  logic [timer_ctl_pkg::CNT_W-1:0] period_r;
  logic event_r;
  timer_ctl_pkg::run_state_t run_r;

  logic trig_start;
  logic trig_reset;
  logic hold_rst;
  logic keep_on;
  logic reserved;
  logic at_match;
  logic clr_on;

  // ****************************************
  // Prescaler and edge sampler
  // ****************************************
  timer_tick_gen u_tick (
    .clock(clock),
    .resetn(resetn),
    .tk(tk)
  );

  assign tk.presc_sel = presc_r;
  assign tk.ext_level = ext_reset_source;
  // Writes to control or count restart the prescaler
  assign tk.presc_clr = wr_ctrl || wr_count;

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_do = aw_held_r && w_held_r && !bvalid_r;
  assign wr_low = wr_do && wstrb_r[0];
  assign wr_ctrl = wr_low && (awaddr_r == timer_ctl_pkg::OFS_CTRL);
  assign wr_limit = wr_low && (awaddr_r == timer_ctl_pkg::OFS_LIMIT);
  assign wr_count = wr_low && (awaddr_r == timer_ctl_pkg::OFS_COUNT);
  assign wr_period = wr_low && (awaddr_r == timer_ctl_pkg::OFS_PERIOD);
  assign wr_mapped = (awaddr_r == timer_ctl_pkg::OFS_CTRL) || (awaddr_r == timer_ctl_pkg::OFS_LIMIT)
                  || (awaddr_r == timer_ctl_pkg::OFS_COUNT) || (awaddr_r == timer_ctl_pkg::OFS_PERIOD)
                  || (awaddr_r == timer_ctl_pkg::OFS_STATUS);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= {s_axi_awaddr[timer_ctl_pkg::ADDR_W-1:2], 2'h0};
    end
    else if (wr_do)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (wr_do)
      w_held_r <= 1'b0;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= timer_ctl_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? timer_ctl_pkg::RESP_OKAY : timer_ctl_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ****************************************
  // AXI4-Lite read channels
  // ****************************************
  assign s_axi_arready = !rvalid_r;
  assign rd_do = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    rd_mux = '0;
    rd_mapped = 1'b1;
    unique case ({s_axi_araddr[timer_ctl_pkg::ADDR_W-1:2], 2'h0})
      timer_ctl_pkg::OFS_CTRL:
      begin
        rd_mux[timer_ctl_pkg::CTRL_ON_BIT] = on_r;
        rd_mux[timer_ctl_pkg::CTRL_PRESC_LSB +: timer_ctl_pkg::PRESC_W] = presc_r;
      end
      timer_ctl_pkg::OFS_LIMIT:
        rd_mux[timer_ctl_pkg::MODE_W-1:0] = mode_r;
      timer_ctl_pkg::OFS_COUNT:
        rd_mux[timer_ctl_pkg::CNT_W-1:0] = count_r;
      timer_ctl_pkg::OFS_PERIOD:
        rd_mux[timer_ctl_pkg::CNT_W-1:0] = period_r;
      timer_ctl_pkg::OFS_STATUS:
      begin
        rd_mux[timer_ctl_pkg::STAT_RUN_BIT] = (run_r == timer_ctl_pkg::RUN_ACTIVE);
        rd_mux[timer_ctl_pkg::STAT_ERS_BIT] = tk.ers_now;
      end
      default:
        rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= timer_ctl_pkg::RESP_OKAY;
    end
    else if (rd_do)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_mapped ? timer_ctl_pkg::RESP_OKAY : timer_ctl_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ****************************************
  // Mode decode
  // ****************************************
  always_comb
  begin
    trig_start = 1'b0;
    trig_reset = 1'b0;
    hold_rst = 1'b0;
    keep_on = 1'b0;
    reserved = 1'b0;
    unique case (mode_r[4:3])
      timer_ctl_pkg::CLS_ONESHOT:
      begin
        unique case (mode_r[2:0])
          timer_ctl_pkg::SUB_SOFT:
            trig_start = 1'b1;
          timer_ctl_pkg::SUB_RISE:
            trig_start = tk.ers_rise;
          timer_ctl_pkg::SUB_FALL:
            trig_start = tk.ers_fall;
          timer_ctl_pkg::SUB_ANY:
            trig_start = tk.ers_rise || tk.ers_fall;
          timer_ctl_pkg::SUB_RISE_RST:
          begin
            trig_start = tk.ers_rise;
            trig_reset = tk.ers_rise;
          end
          timer_ctl_pkg::SUB_FALL_RST:
          begin
            trig_start = tk.ers_fall;
            trig_reset = tk.ers_fall;
          end
          timer_ctl_pkg::SUB_LVL_LOW:
          begin
            trig_start = tk.ers_rise;
            hold_rst = !tk.ers_now;
          end
          timer_ctl_pkg::SUB_LVL_HIGH:
          begin
            trig_start = tk.ers_fall;
            hold_rst = tk.ers_now;
          end
        endcase
      end
      timer_ctl_pkg::CLS_MONO:
      begin
        unique case (mode_r[2:0])
          timer_ctl_pkg::SUB_RISE:
          begin
            trig_start = tk.ers_rise;
            keep_on = 1'b1;
          end
          timer_ctl_pkg::SUB_FALL:
          begin
            trig_start = tk.ers_fall;
            keep_on = 1'b1;
          end
          timer_ctl_pkg::SUB_ANY:
          begin
            trig_start = tk.ers_rise || tk.ers_fall;
            keep_on = 1'b1;
          end
          timer_ctl_pkg::SUB_LVL_LOW:
          begin
            trig_start = tk.ers_now;
            hold_rst = !tk.ers_now;
          end
          timer_ctl_pkg::SUB_LVL_HIGH:
          begin
            trig_start = !tk.ers_now;
            hold_rst = tk.ers_now;
          end
          default:
            reserved = 1'b1;
        endcase
      end
      default:
        reserved = 1'b1;
    endcase
  end

  assign at_match = (count_r == period_r);
  // Match seen on a tick ends the run; one-shot and level-triggered monostable modes drop enable as well
  assign clr_on = tk.tick && on_r && !reserved && !hold_rst && (run_r == timer_ctl_pkg::RUN_ACTIVE)
               && !trig_reset && at_match && !keep_on;

  // ****************************************
  // Control, mode and period registers
  // ****************************************
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      on_r <= 1'b0;
      presc_r <= timer_ctl_pkg::PRESC_RST;
    end
    else if (wr_ctrl)
    begin
      on_r <= wdata_r[timer_ctl_pkg::CTRL_ON_BIT];
      presc_r <= wdata_r[timer_ctl_pkg::CTRL_PRESC_LSB +: timer_ctl_pkg::PRESC_W];
    end
    else if (clr_on)
      on_r <= 1'b0;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      mode_r <= timer_ctl_pkg::MODE_RST;
    else if (wr_limit)
      mode_r <= wdata_r[timer_ctl_pkg::MODE_W-1:0];
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      period_r <= timer_ctl_pkg::PERIOD_RST;
    else if (wr_period)
      period_r <= wdata_r[timer_ctl_pkg::CNT_W-1:0];
  end

  // ****************************************
  // Run state: edges act only while enabled
  // ****************************************
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      run_r <= timer_ctl_pkg::RUN_IDLE;
    else if (tk.tick)
    begin
      if (!on_r || reserved)
        run_r <= timer_ctl_pkg::RUN_IDLE;
      else if (hold_rst)
        run_r <= timer_ctl_pkg::RUN_IDLE;
      else if (run_r == timer_ctl_pkg::RUN_ACTIVE)
      begin
        if (!trig_reset && at_match)
          run_r <= timer_ctl_pkg::RUN_IDLE;
      end
      else if (trig_start)
        run_r <= timer_ctl_pkg::RUN_ACTIVE;
    end
  end

  // ****************************************
  // Count register
  // ****************************************
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      count_r <= timer_ctl_pkg::COUNT_RST;
    else if (wr_count)
      count_r <= wdata_r[timer_ctl_pkg::CNT_W-1:0];
    else if (tk.tick && on_r && !reserved)
    begin
      if (hold_rst)
        count_r <= timer_ctl_pkg::COUNT_RST;
      else if (run_r == timer_ctl_pkg::RUN_ACTIVE)
      begin
        if (trig_reset)
          count_r <= timer_ctl_pkg::COUNT_RST;
        else if (at_match)
          count_r <= timer_ctl_pkg::COUNT_RST;
        else
          count_r <= count_r + 8'h01;
      end
    end
  end

  // Period event pulse, one clock wide, when a match stops the count
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      event_r <= 1'b0;
    else
      event_r <= tk.tick && on_r && !reserved && !hold_rst && (run_r == timer_ctl_pkg::RUN_ACTIVE)
              && !trig_reset && at_match && !wr_count;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign count_value = count_r;
  assign period_event = event_r;
  assign timer_running = (run_r == timer_ctl_pkg::RUN_ACTIVE);

endmodule : timer_oneshot_monostable_ctl

// ### ext_src_model.sv
// Far-side logic that drives the external reset source level
`timescale 1ns/10ps
module ext_src_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic level_req,
  input wire logic [3:0] min_gap,
  output logic ext_reset_source
);
  // ****
  // Follows the requested level, never changing sooner than min_gap clocks
  // ****
  logic [3:0] gap_r;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_reset_source <= 1'b0;
      gap_r <= 4'h0;
    end
    else if (level_req != ext_reset_source && gap_r >= min_gap)
    begin
      ext_reset_source <= level_req;
      gap_r <= 4'h0;
    end
    else if (gap_r != 4'hF)
    begin
      gap_r <= gap_r + 4'h1;
    end
  end
endmodule : ext_src_model

// ### timer_ctl_checker.sv
// Concurrent checks on the ports of the timer control block
`timescale 1ns/10ps
module timer_ctl_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [timer_ctl_pkg::CNT_W-1:0] count_value,
  input wire logic period_event,
  input wire logic timer_running
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_event_zero: assert property (period_event |-> count_value == 8'h00)
    else $error("count not zero at period event");
  a_event_pulse: assert property (period_event |=> !period_event)
    else $error("period event longer than one cycle");
  a_event_cause: assert property ($rose(period_event) |-> $past(timer_running) && !timer_running)
    else $error("period event without a running count");
  a_count_step: assert property (!$rose(s_axi_bvalid) |-> count_value == $past(count_value)
    || count_value == 8'($past(count_value) + 8'h01) || count_value == 8'h00)
    else $error("count moved by other than one step or clear");
  a_stop_hold: assert property (!timer_running && !$past(timer_running) && !$rose(s_axi_bvalid)
    |-> $stable(count_value))
    else $error("stopped count changed");
  a_reset_clear: assert property ($rose(resetn) |-> count_value == 8'h00 && !timer_running)
    else $error("count or run state not cleared by reset");
  a_write_lock: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_lock: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  c_event: cover property (period_event);
  c_start: cover property ($rose(timer_running));
  c_write: cover property ($rose(s_axi_bvalid));
endmodule : timer_ctl_checker

bind timer_oneshot_monostable_ctl timer_ctl_checker i_chk (.clock, .resetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .count_value,
  .period_event, .timer_running);

// ### timer_oneshot_monostable_ctl_tb.sv
// Self-checking bench for the timer start, stop and reset control
`timescale 1ns/10ps
module timer_oneshot_monostable_ctl_tb;
  // ****
  // Signals
  // ****
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic src_req = 1'b0;
  logic [3:0] src_gap = 4'h6;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] strb = 4'hF;
  logic ext_src, awready, wready, bvalid, arready, rvalid, pev, run;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata, rd_val;
  logic [7:0] cnt, r8;
  logic [15:0] lfsr = 16'h34D3;
  logic [4:0] run_modes [10] = '{5'h09, 5'h0A, 5'h0B, 5'h11, 5'h12, 5'h13, 5'h16, 5'h17, 5'h0E, 5'h0F};
  logic [4:0] rst_modes [6] = '{5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h16, 5'h17};
  logic [4:0] res_modes [4] = '{5'h10, 5'h14, 5'h15, 5'h1B};
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  initial forever #10 clock = ~clock;

  ext_src_model i_src (.clock(clock), .resetn(resetn), .level_req(src_req), .min_gap(src_gap),
    .ext_reset_source(ext_src));
  timer_oneshot_monostable_ctl i_dut (.clock(clock), .resetn(resetn), .ext_reset_source(ext_src),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .count_value(cnt), .period_event(pev), .timer_running(run));

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ****
  // Helpers
  // ****
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  function automatic logic start_lvl(input logic [4:0] m);
    return m[2:0] inside {3'h2, 3'h5, 3'h7};
  endfunction : start_lvl

  function automatic logic [31:0] exp_en(input logic [4:0] m);
    return 32'(m[4:3] == timer_ctl_pkg::CLS_MONO && m[2:0] inside {3'h1, 3'h2, 3'h3});
  endfunction : exp_en

  task automatic chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_data

  task automatic chk_resp(input string n, input logic [1:0] e);
    chk_data(n, 32'(e), 32'(last_resp));
  endtask : chk_resp

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    last_resp = bresp;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd_val = rdata;
    last_resp = rresp;
  endtask : rd

  task automatic set_src(input logic v);
    src_req <= v;
    do
      @(posedge clock);
    while (ext_src !== v);
  endtask : set_src

  task automatic prep(input logic [4:0] m, input logic [7:0] per, input logic sel);
    wr(timer_ctl_pkg::OFS_CTRL, 32'h0);
    wr(timer_ctl_pkg::OFS_COUNT, 32'h0);
    wr(timer_ctl_pkg::OFS_PERIOD, 32'(per));
    set_src(start_lvl(m));
    wr(timer_ctl_pkg::OFS_LIMIT, 32'(m));
    wr(timer_ctl_pkg::OFS_CTRL, (32'(sel) << 4) | 32'h1);
    set_src(!start_lvl(m));
  endtask : prep

  task automatic run_mode(input logic [4:0] m, input logic sel);
    logic [7:0] per;
    int n;
    per = 8'h02 + 8'(rnd() & 16'h7);
    n = 0;
    src_gap <= sel ? 4'hD : 4'h6;
    prep(m, per, sel);
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pev !== 1'b1 && n < 2000);
    chk_data("event delay", 32'h1, 32'(n > (int'(per + 8'h01) << sel) && n <= (int'(per + 8'h01) << sel) + 2));
    repeat (2) @(posedge clock);
    chk_data("stopped", 32'h0, 32'({cnt, run}));
    rd(timer_ctl_pkg::OFS_CTRL);
    chk_data("enable after match", exp_en(m), rd_val & 32'h1);
    $display("test run mode %b done", m);
  endtask : run_mode

  task automatic rst_test(input logic [4:0] m);
    src_gap <= 4'h6;
    prep(m, 8'h60, 1'b0);
    repeat (8) @(posedge clock);
    chk_data("started", 32'h1, 32'(run));
    set_src(start_lvl(m));
    repeat (3) @(posedge clock);
    if (m[2:1] == 2'b10)
    begin
      set_src(!start_lvl(m));
      repeat (2) @(posedge clock);
      chk_data("edge reset", 32'h1, 32'(cnt < 8'h05 && run));
    end
    else
      chk_data("level reset", 32'h0, 32'({cnt, run}));
    $display("test reset mode %b done", m);
  endtask : rst_test

  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(timer_ctl_pkg::OFS_PERIOD);
    chk_data("period reset", 32'hFF, rd_val);
    rd(timer_ctl_pkg::OFS_COUNT);
    chk_data("count reset", 32'h0, rd_val);
    rd(timer_ctl_pkg::OFS_LIMIT);
    chk_data("mode reset", 32'h0, rd_val);
    rd(5'h14);
    chk_resp("unmapped read", timer_ctl_pkg::RESP_SLVERR);
    wr(5'h18, 32'h1);
    chk_resp("unmapped write", timer_ctl_pkg::RESP_SLVERR);
    strb <= 4'h0;
    wr(timer_ctl_pkg::OFS_PERIOD, 32'h33);
    strb <= 4'hF;
    rd(timer_ctl_pkg::OFS_PERIOD);
    chk_data("masked write", 32'hFF, rd_val);
    r8 = 8'(rnd());
    wr(timer_ctl_pkg::OFS_COUNT, 32'(r8));
    rd(timer_ctl_pkg::OFS_COUNT);
    chk_data("count write", 32'(r8), rd_val);
    set_src(1'b1);
    rd(timer_ctl_pkg::OFS_STATUS);
    chk_data("source level", 32'h2, rd_val & 32'h2);
    $display("test registers done");
    wr(timer_ctl_pkg::OFS_LIMIT, 32'h09);
    set_src(1'b0);
    set_src(1'b1);
    wr(timer_ctl_pkg::OFS_CTRL, 32'h1);
    repeat (8) @(posedge clock);
    chk_data("stale edge", 32'h0, 32'(run));
    $display("test stale edge done");
    foreach (res_modes[i])
    begin
      wr(timer_ctl_pkg::OFS_CTRL, 32'h0);
      wr(timer_ctl_pkg::OFS_COUNT, 32'h5);
      wr(timer_ctl_pkg::OFS_LIMIT, 32'(res_modes[i]));
      wr(timer_ctl_pkg::OFS_CTRL, 32'h1);
      set_src(1'b0);
      set_src(1'b1);
      repeat (4) @(posedge clock);
      chk_data("reserved", 32'hA, 32'({cnt, run}));
      $display("test reserved mode %b done", res_modes[i]);
    end
    wr(timer_ctl_pkg::OFS_CTRL, 32'h0);
    wr(timer_ctl_pkg::OFS_COUNT, 32'h0);
    wr(timer_ctl_pkg::OFS_PERIOD, 32'h3);
    wr(timer_ctl_pkg::OFS_LIMIT, 32'h08);
    wr(timer_ctl_pkg::OFS_CTRL, 32'h1);
    repeat (5) @(posedge clock);
    chk_data("software start", 32'h1, 32'({cnt, run, pev}));
    rd(timer_ctl_pkg::OFS_CTRL);
    chk_data("software stop", 32'h0, rd_val & 32'h1);
    $display("test software start done");
    foreach (run_modes[i])
      run_mode(run_modes[i], 1'(rnd()));
    foreach (rst_modes[i])
      rst_test(rst_modes[i]);
    stop_test();
  end
endmodule : timer_oneshot_monostable_ctl_tb
